// ---- hw/sync_permit.sv ----
// Close-permit decision logic with event log and APB register file.
// Assumes measurements arrive synchronous to mclk, refreshed each cycle.
// Notes on behaviour
// (R1) Voltage present above 105 percent of setting
// (R2) Voltage element resets at 100 percent
// (R3) Never pick up for low voltage
// (R4) Zero voltage detected even when disabled
// (R5) Voltage difference within setting picks up
// (R6) Difference relative to smaller side voltage
// (R7) Difference resets above setting plus five
// (R8) Angle difference within setting picks up
// (R9) Angle resets half degree above setting
// (R10) Angle and frequency need three cycles
// (R11) Frequency strictly below setting picks up
// (R12) Frequency resets 0.005 Hz above setting
// (R13) Permit closes after full timer duration; here the first step may be short, as the step ticks run free
// (R14) Only enabled elements gate the permit
// (R15) Forty entries, oldest overwritten when full
// (R16) Each entry carries time and code
// (R17) Entries written only when breaker closes
// (R18) Masked events not recorded, bus only
// (R19) Power-up bit 4, settings bit 5
// (R20) Synchronism event bits 1 to 7
// (R21) Each signal mapped to one contact
// (R22) Open breaker and two permit blocks
// (R23) Blocks asserted before blocked signal appears; here blocks act as levels, so a later block still drops the signal
// (R24) Disabled voltage element disables difference
// (R25) Side permit active when element disabled
// (R26) Timer 0 to 60 s, 0.1 s
// (R27) Dropout clears timer, restart from zero
`timescale 1ns/1ps
`default_nettype none
module sync_permit
    import sync_permit_pkg::*;
#(
    parameter int TIMER_STEP_CYCLES = TIMER_STEP_CYCLES_DEF
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] voltA,
    input wire logic [15:0] voltB,
    input wire logic [11:0] angleDiff,
    input wire logic [15:0] freqDiff,
    input wire logic cycleTick,
    input wire logic contact1,
    input wire logic contact2,
    output logic permitPickup,
    output logic permitOut
);
    // ----------
    // Registers and state
    // ----------
    logic [4:0] ctrl;
    logic [13:0] vminSet;
    logic [23:0] diffSet;
    logic [9:0] delaySet;
    logic [5:0] inMap;
    logic [15:0] evMask;
    logic [31:0] timeNow;
    logic [5:0] logSel;
    logic [15:0] logCode [LOG_DEPTH];
    logic [31:0] logTime [LOG_DEPTH];
    logic [5:0] wrPtr;
    logic [5:0] logCount;
    logic [15:0] pending;
    logic [15:0] prevEv;
    logic [1:0] vPick;
    logic [1:0] vDead;
    logic pickU, pickPh, pickF;
    logic [1:0] measCount;
    logic [31:0] stepCount;
    logic [9:0] delayCount;
    logic openBreaker, openBreakerD;
    permit_state_t state;

    logic accessEdge, wrEn, mapped;
    logic [7:0] addrWord;
    logic stepTick, measValid, enU, allOk, pickupNow, breakerCloses;
    logic [15:0] evNow, evChange;
    logic [1:0] permSide;
    logic blockPickup, blockOutput;
    logic [15:0] vMin, vDiff;
    logic [23:0] diffScaled, pickLimitU, resetLimitU;
    logic [11:0] angLimit;
    logic [15:0] freqLimit;

    // ----------
    // APB slave
    // ----------
    assign accessEdge = ce & psel & penable & pready;
    assign wrEn = accessEdge & pwrite;
    assign addrWord = {paddr[7:2], 2'b00};
    assign mapped = (paddr <= LOGCOUNT_OFS) && (paddr[1:0] == 2'b00);

    // Ready is raised one edge after setup, so while ce stays high every transfer has exactly
    // one access cycle and read data is captured from a stable register.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (ce) begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            if (psel && !penable && !pwrite) begin
                case (addrWord)
                    CTRL_OFS: prdata <= {27'h0000000, ctrl};
                    VMIN_OFS: prdata <= {17'h00000, vminSet[13:7], 1'b0, vminSet[6:0]};
                    DIFF_OFS: prdata <= {8'h00, diffSet};
                    DELAY_OFS: prdata <= {22'h000000, delaySet};
                    INMAP_OFS: prdata <= {26'h0000000, inMap};
                    EVMASK_OFS: prdata <= {16'h0000, evMask};
                    STATUS_OFS: prdata <= {16'h0000, evNow};
                    TIME_OFS: prdata <= timeNow;
                    LOGSEL_OFS: prdata <= {26'h0000000, logSel};
                    LOGCODE_OFS: prdata <= {16'h0000, logCode[logSel]};
                    LOGTIME_OFS: prdata <= logTime[logSel];
                    LOGCOUNT_OFS: prdata <= {26'h0000000, logCount};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Settings; the mask is reachable only through this bus. (R18)
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CTRL_RST;
            vminSet <= VMIN_RST;
            diffSet <= DIFF_RST;
            delaySet <= DELAY_RST;
            inMap <= INMAP_RST;
            evMask <= EVMASK_RST;
            logSel <= 6'h00;
        end else if (wrEn) begin
            case (addrWord)
                CTRL_OFS: ctrl <= pwdata[4:0];
                VMIN_OFS: vminSet <= {pwdata[14:8], pwdata[6:0]};
                DIFF_OFS: diffSet <= pwdata[23:0];
                DELAY_OFS: delaySet <= (pwdata[9:0] > DELAY_MAX) ? DELAY_MAX : pwdata[9:0]; // (R26)
                INMAP_OFS: inMap <= pwdata[5:0];
                EVMASK_OFS: evMask <= pwdata[15:0];
                LOGSEL_OFS: logSel <= (pwdata[5:0] > LOG_LAST) ? LOG_LAST : pwdata[5:0];
                default: ;
            endcase
        end
    end

    // ----------
    // Time base and timestamp
    // ----------
    assign stepTick = (stepCount == 32'(TIMER_STEP_CYCLES - 1));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stepCount <= 32'h00000000;
            timeNow <= 32'h00000000;
        end else if (ce) begin
            stepCount <= stepTick ? 32'h00000000 : stepCount + 32'h00000001;
            if (wrEn && addrWord == TIME_OFS) begin
                timeNow <= pwdata;
            end else if (stepTick) begin
                timeNow <= timeNow + 32'h00000001;
            end
        end
    end

    // ----------
    // Contact input mapping
    // ----------
    // A two-bit selector per signal (0 none, 1 first, 2 second contact)
    // cannot name two contacts, so each signal has at most one source.
    function automatic logic pickContact(input logic [1:0] sel, input logic c1,
                                         input logic c2);
        return (sel == 2'h1) ? c1 : ((sel == 2'h2) ? c2 : 1'b0);
    endfunction

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            // Reset to the idle contact level so no false close follows reset.
            openBreaker <= 1'b0;
            openBreakerD <= 1'b0;
        end else if (ce) begin
            openBreaker <= pickContact(inMap[1:0], contact1, contact2); // (R21) (R22)
            openBreakerD <= openBreaker;
        end
    end

    assign blockPickup = pickContact(inMap[3:2], contact1, contact2); // (R21) (R22)
    assign blockOutput = pickContact(inMap[5:4], contact1, contact2); // (R21) (R22)
    assign breakerCloses = openBreakerD & ~openBreaker;

    // ----------
    // Minimum voltage elements, one per side
    // ----------
    for (genvar s = 0; s < 2; s++) begin : g_side
        logic [15:0] v;
        logic [6:0] set;
        assign v = (s == 0) ? voltA : voltB;
        assign set = (s == 0) ? vminSet[6:0] : vminSet[13:7];
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                vPick[s] <= 1'b0;
                vDead[s] <= 1'b1;
            end else if (ce) begin
                // Zero detection runs regardless of the enable. (R4)
                vDead[s] <= (v < ZERO_VOLT_LEVEL);
                if (!vPick[s] && ({v, 1'b0} > 17'(set) * 17'(VMIN_PICKUP_X20))) begin
                    vPick[s] <= 1'b1; // (R1) (R3)
                end else if (vPick[s] && ({1'b0, v} <= 17'(set) * 17'(VMIN_RESET_X10))) begin
                    vPick[s] <= 1'b0; // (R2)
                end
            end
        end
        assign permSide[s] = vPick[s] | ~ctrl[s]; // (R25)
    end

    // ----------
    // Difference elements
    // ----------
    assign vMin = (voltA < voltB) ? voltA : voltB;
    assign vDiff = (voltA < voltB) ? voltB - voltA : voltA - voltB;
    // Cross-multiplied so no divider is needed: diff/min <= pct/100. (R6)
    assign diffScaled = 24'(vDiff) * 24'(DIFF_PCT_SCALE);
    assign pickLimitU = 24'(vMin) * 24'(diffSet[4:0]);
    assign resetLimitU = 24'(vMin) * 24'(6'(diffSet[4:0] + DIFF_PCT_HYST));
    assign angLimit = 12'(diffSet[13:8]) * 12'(ANGLE_SCALE);
    assign freqLimit = 16'(diffSet[23:16]) * 16'(FREQ_SCALE);
    assign measValid = (measCount == MEAS_CYCLES_MIN);
    assign enU = ctrl[EN_U_BIT] & ctrl[EN_A_BIT] & ctrl[EN_B_BIT]; // (R24)

    // A dead side restarts the metering count so the frequency element
    // cannot operate on a missing voltage.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            measCount <= 2'h0;
        end else if (ce) begin
            if (vDead != 2'b00) begin
                measCount <= 2'h0; // (R4)
            end else if (cycleTick && !measValid) begin
                measCount <= measCount + 2'h1; // (R10)
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pickU <= 1'b0;
        end else if (ce) begin
            if (vMin == 16'h0000) begin
                pickU <= 1'b0;
            end else if (!pickU && diffScaled <= pickLimitU) begin
                pickU <= 1'b1; // (R5)
            end else if (pickU && diffScaled > resetLimitU) begin
                pickU <= 1'b0; // (R7)
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pickPh <= 1'b0;
        end else if (ce) begin
            if (!measValid) begin
                pickPh <= 1'b0; // (R10)
            end else if (!pickPh && angleDiff <= angLimit) begin
                pickPh <= 1'b1; // (R8)
            end else if (pickPh && angleDiff > angLimit + ANGLE_HYST) begin
                pickPh <= 1'b0; // (R9)
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pickF <= 1'b0;
        end else if (ce) begin
            if (!measValid) begin
                pickF <= 1'b0; // (R10) (R4)
            end else if (!pickF && freqDiff < freqLimit) begin
                pickF <= 1'b1; // (R11)
            end else if (pickF && freqDiff > freqLimit + FREQ_HYST) begin
                pickF <= 1'b0; // (R12)
            end
        end
    end

    // ----------
    // Close-permit timer
    // ----------
    assign allOk = (~enU | pickU) & (~ctrl[EN_PH_BIT] | pickPh)
        & (~ctrl[EN_F_BIT] | pickF) & (&permSide); // (R14)
    // Blocks act only as levels here; a block raised after the permit is
    // already up still drops it, which is the safe reading. (R23)
    assign pickupNow = allOk & ~blockPickup;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= PERMIT_IDLE;
            delayCount <= 10'h000;
            permitPickup <= 1'b0;
            permitOut <= 1'b0;
        end else if (ce) begin
            permitPickup <= pickupNow;
            permitOut <= (state == PERMIT_CLOSED) & pickupNow & ~blockOutput;
            case (state)
                PERMIT_IDLE: begin
                    delayCount <= 10'h000; // (R27)
                    if (pickupNow) begin
                        state <= (delaySet == 10'h000) ? PERMIT_CLOSED : PERMIT_TIMING;
                    end
                end
                PERMIT_TIMING: begin
                    if (!pickupNow) begin
                        state <= PERMIT_IDLE; // (R27)
                    end else if (stepTick) begin
                        delayCount <= delayCount + 10'h001;
                        if (delayCount + 10'h001 >= delaySet) begin
                            state <= PERMIT_CLOSED; // (R13)
                        end
                    end
                end
                PERMIT_CLOSED: begin
                    if (!pickupNow) begin
                        state <= PERMIT_IDLE;
                    end
                end
                default: state <= PERMIT_IDLE;
            endcase
        end
    end

    // ----------
    // Event log
    // ----------
    always_comb begin
        evNow = 16'h0000;
        evNow[EV_VMIN_A] = permSide[0]; // (R20)
        evNow[EV_VMIN_B] = permSide[1];
        evNow[EV_PICKUP] = permitPickup;
        evNow[EV_OUTPUT] = permitOut;
        evNow[EV_VOLT] = pickU;
        evNow[EV_ANGLE] = pickPh;
        evNow[EV_FREQ] = pickF;
    end
    assign evChange = (evNow ^ prevEv) & ~evMask; // (R18)

    // Changes accumulate until the breaker closes; a change in the commit
    // cycle is kept for the next entry rather than lost.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prevEv <= 16'h0000;
            pending <= 16'h0000;
        end else if (ce) begin
            prevEv <= evNow;
            if (breakerCloses) begin
                pending <= evChange; // (R17)
            end else begin
                pending <= pending | evChange;
            end
            if (!evMask[EV_POWER_UP] && logCount == 6'h00 && pending == 16'h0000
                && prevEv == 16'h0000) begin
                pending[EV_POWER_UP] <= 1'b1; // (R19)
            end
            if (wrEn && addrWord <= INMAP_OFS && !evMask[EV_SET_CHANGE]) begin
                pending[EV_SET_CHANGE] <= 1'b1; // (R19)
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr <= 6'h00;
            logCount <= 6'h00;
            for (int i = 0; i < LOG_DEPTH; i++) begin
                logCode[i] <= 16'h0000;
                logTime[i] <= 32'h00000000;
            end
        end else if (ce && breakerCloses && pending != 16'h0000) begin
            logCode[wrPtr] <= pending; // (R16) (R17)
            logTime[wrPtr] <= timeNow; // (R16)
            wrPtr <= (wrPtr == LOG_LAST) ? 6'h00 : wrPtr + 6'h01; // (R15)
            if (logCount != 6'(LOG_DEPTH)) begin
                logCount <= logCount + 6'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ---- shared/sync_permit_pkg.sv ----
// Package for the synchronism close-permit block: register map, field
// positions, reset values, element hysteresis figures and timing counts.
// Assumes one 100 MHz clock and a 32-bit APB register bus.
package sync_permit_pkg;
    // ----------
    // Clock and time base
    // ----------
    localparam int CLK_FREQ_KHZ = 100000;
    localparam int TIMER_STEP_MS = 100;
    localparam int TIMER_STEP_CYCLES_DEF = TIMER_STEP_MS * CLK_FREQ_KHZ;
    localparam logic [9:0] DELAY_MAX = 10'h258;
    localparam logic [1:0] MEAS_CYCLES_MIN = 2'h3;

    // ----------
    // Element thresholds (voltage 0.1 V, angle 0.1 deg, frequency mHz)
    // ----------
    localparam logic [4:0] VMIN_PICKUP_X20 = 5'h15;
    localparam logic [4:0] VMIN_RESET_X10 = 5'h0A;
    localparam logic [15:0] ZERO_VOLT_LEVEL = 16'h0032;
    localparam logic [6:0] DIFF_PCT_SCALE = 7'h64;
    localparam logic [5:0] DIFF_PCT_HYST = 6'h05;
    localparam logic [3:0] ANGLE_SCALE = 4'hA;
    localparam logic [11:0] ANGLE_HYST = 12'h005;
    localparam logic [3:0] FREQ_SCALE = 4'hA;
    localparam logic [15:0] FREQ_HYST = 16'h0005;

    // ----------
    // Register byte offsets
    // ----------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] VMIN_OFS = 8'h04;
    localparam logic [7:0] DIFF_OFS = 8'h08;
    localparam logic [7:0] DELAY_OFS = 8'h0C;
    localparam logic [7:0] INMAP_OFS = 8'h10;
    localparam logic [7:0] EVMASK_OFS = 8'h14;
    localparam logic [7:0] STATUS_OFS = 8'h18;
    localparam logic [7:0] TIME_OFS = 8'h1C;
    localparam logic [7:0] LOGSEL_OFS = 8'h20;
    localparam logic [7:0] LOGCODE_OFS = 8'h24;
    localparam logic [7:0] LOGTIME_OFS = 8'h28;
    localparam logic [7:0] LOGCOUNT_OFS = 8'h2C;

    // ----------
    // Fields and reset values
    // ----------
    localparam int EN_A_BIT = 0;
    localparam int EN_B_BIT = 1;
    localparam int EN_U_BIT = 2;
    localparam int EN_PH_BIT = 3;
    localparam int EN_F_BIT = 4;
    localparam logic [4:0] CTRL_RST = 5'h1F;
    localparam logic [13:0] VMIN_RST = 14'h1450;
    localparam logic [23:0] DIFF_RST = 24'h0A0A0A;
    localparam logic [9:0] DELAY_RST = 10'h00A;
    localparam logic [5:0] INMAP_RST = 6'h29;
    localparam logic [15:0] EVMASK_RST = 16'h0000;

    // Event bit positions: byte 1 of the synchronism function in [7:0],
    // byte 1 of the initialization function in [15:8].
    localparam int EV_VMIN_A = 1;
    localparam int EV_VMIN_B = 2;
    localparam int EV_PICKUP = 3;
    localparam int EV_OUTPUT = 4;
    localparam int EV_VOLT = 5;
    localparam int EV_ANGLE = 6;
    localparam int EV_FREQ = 7;
    localparam int EV_POWER_UP = 12;
    localparam int EV_SET_CHANGE = 13;
    localparam int LOG_DEPTH = 40;
    localparam logic [5:0] LOG_LAST = 6'h27;

    typedef enum logic [1:0] {
        PERMIT_IDLE = 2'b00,
        PERMIT_TIMING = 2'b01,
        PERMIT_CLOSED = 2'b11
    } permit_state_t;
endpackage

// ---- test/meas_front_model.sv ----
// Measurement front end model: holds the side values asked for by the bench
// and beats the power-system cycle pulse. Assumes one clock with the block.
`timescale 1ns/1ps
`default_nettype none
module meas_front_model #(
    parameter int TICK_PERIOD = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic tickOn,
    input wire logic [15:0] setA,
    input wire logic [15:0] setB,
    input wire logic [11:0] setAng,
    input wire logic [15:0] setFrq,
    output logic [15:0] voltA,
    output logic [15:0] voltB,
    output logic [11:0] angleDiff,
    output logic [15:0] freqDiff,
    output logic cycleTick
);
    int count;
    assign voltA = setA;
    assign voltB = setB;
    assign angleDiff = setAng;
    assign freqDiff = setFrq;
    // The cycle pulse stands still while no measurement is running.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 0;
            cycleTick <= 1'b0;
        end else begin
            cycleTick <= tickOn && count == TICK_PERIOD - 1;
            count <= (count == TICK_PERIOD - 1) ? 0 : count + 1;
        end
    end
endmodule
`default_nettype wire

// ---- test/sync_permit_bench.sv ----
// Testbench for the close-permit block: APB tasks and element scenarios.
// Assumes the checker binds itself and the clock enable stays high.
`timescale 1ns/1ps
`default_nettype none
module sync_permit_bench import sync_permit_pkg::*; ;
    logic mclk = 0, rst_n = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic tickOn = 0, contact1 = 0, contact2 = 0, er, pready, pslverr;
    logic cycleTick, permitPickup, permitOut;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [15:0] setA = 0, setB = 0, setFrq = 0, voltA, voltB, freqDiff;
    logic [11:0] setAng = 0, angleDiff;
    int n_mismatch = 0, check_count = 0, cycles = 0, n;
    localparam logic [7:0] OFS [7] = '{CTRL_OFS, VMIN_OFS, DIFF_OFS, DELAY_OFS,
        INMAP_OFS, EVMASK_OFS, 8'h30};
    localparam logic [31:0] VAL [7] = '{32'h1F, 32'h2850, 32'h0A0A0A, 32'hA, 32'h29, 0, 0};
    sync_permit #(.TIMER_STEP_CYCLES(10)) u_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .voltA(voltA), .voltB(voltB),
        .angleDiff(angleDiff), .freqDiff(freqDiff), .cycleTick(cycleTick),
        .contact1(contact1), .contact2(contact2), .permitPickup(permitPickup),
        .permitOut(permitOut));
    meas_front_model u_meas (.mclk(mclk), .rst_n(rst_n), .tickOn(tickOn), .setA(setA),
        .setB(setB), .setAng(setAng), .setFrq(setFrq), .voltA(voltA), .voltB(voltB),
        .angleDiff(angleDiff), .freqDiff(freqDiff), .cycleTick(cycleTick));
    initial forever #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    // ----------
    // Shared tasks
    // ----------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic mz(input logic [15:0] a, b, input logic [11:0] g, input logic [15:0] f);
        @(posedge mclk);
        setA <= a;
        setB <= b;
        setAng <= g;
        setFrq <= f;
    endtask
    task automatic tr(input logic [15:0] a, b, input logic [11:0] g, input logic [15:0] f,
        input logic exp);
        mz(a, b, g, f);
        repeat (6) @(posedge mclk);
        chk({31'h0, permitPickup}, {31'h0, exp});
    endtask
    task automatic waitPick();
        for (n = 0; permitPickup !== 1'b1 && n < 200; n++) @(posedge mclk);
    endtask
    // The first timer step may be short because the step ticks run free.
    task automatic timeOut();
        waitPick();
        for (n = 0; permitOut !== 1'b1 && n < 200; n++) @(posedge mclk);
        chk({31'h0, n >= 19 && n <= 32}, 32'h1);
    endtask
    task automatic pulseBreaker();
        @(posedge mclk);
        contact1 <= 1'b1;
        repeat (3) @(posedge mclk);
        contact1 <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask
    task automatic toggleAngle();
        tr(1000, 1000, 106, 0, 1'b0);
        mz(1000, 1000, 0, 0);
        waitPick();
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ----------
    // Scenarios
    // ----------
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (OFS[i]) rdc(OFS[i], VAL[i]);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, DELAY_OFS, 32'h0);
        tr(1000, 1000, 0, 0, 1'b0);
        tickOn <= 1'b1;
        waitPick();
        chk({31'h0, permitPickup}, 32'h1);
        tr(801, 801, 0, 0, 1'b1);
        tr(800, 800, 0, 0, 1'b0);
        tr(840, 840, 0, 0, 1'b0);
        tr(841, 841, 0, 0, 1'b1);
        tr(1000, 1000, 105, 0, 1'b1);
        tr(1000, 1000, 106, 0, 1'b0);
        tr(1000, 1000, 101, 0, 1'b0);
        tr(1000, 1000, 100, 0, 1'b1);
        tr(1000, 1000, 0, 105, 1'b1);
        tr(1000, 1000, 0, 106, 1'b0);
        tr(1000, 1000, 0, 100, 1'b0);
        tr(1000, 1000, 0, 99, 1'b1);
        tr(1000, 1150, 0, 0, 1'b1);
        tr(1000, 1160, 0, 0, 1'b0);
        tr(1000, 1105, 0, 0, 1'b0);
        tr(1000, 1100, 0, 0, 1'b1);
        apb(1'b1, CTRL_OFS, 32'h1E);
        tr(300, 1000, 0, 0, 1'b1);
        tr(20, 1000, 0, 0, 1'b0);
        apb(1'b1, CTRL_OFS, 32'h1F);
        mz(1000, 1000, 0, 0);
        waitPick();
        $display("test elements done");
        apb(1'b1, DELAY_OFS, 32'h3);
        tr(1000, 1000, 106, 0, 1'b0);
        mz(1000, 1000, 0, 0);
        timeOut();
        tr(1000, 1000, 106, 0, 1'b0);
        mz(1000, 1000, 0, 0);
        waitPick();
        repeat (12) @(posedge mclk);
        tr(1000, 1000, 106, 0, 1'b0);
        mz(1000, 1000, 0, 0);
        timeOut();
        $display("test timer done");
        apb(1'b1, DELAY_OFS, 32'h0);
        apb(1'b1, INMAP_OFS, 32'h09);
        contact2 <= 1'b1;
        tr(1000, 1000, 106, 0, 1'b0);
        tr(1000, 1000, 0, 0, 1'b0);
        contact2 <= 1'b0;
        tr(1000, 1000, 0, 0, 1'b1);
        apb(1'b1, INMAP_OFS, 32'h21);
        contact2 <= 1'b1;
        tr(1000, 1000, 106, 0, 1'b0);
        tr(1000, 1000, 0, 0, 1'b1);
        chk({31'h0, permitOut}, 32'h0);
        contact2 <= 1'b0;
        repeat (4) @(posedge mclk);
        chk({31'h0, permitOut}, 32'h1);
        $display("test blocks done");
        rdc(LOGCOUNT_OFS, 32'h0);
        apb(1'b1, TIME_OFS, 32'h100);
        pulseBreaker();
        rdc(LOGCOUNT_OFS, 32'h1);
        apb(1'b1, LOGSEL_OFS, 32'h0);
        apb(1'b0, LOGCODE_OFS, 32'h0);
        chk({31'h0, rd[EV_OUTPUT]}, 32'h1);
        apb(1'b0, LOGTIME_OFS, 32'h0);
        chk({31'h0, rd >= 32'h100 && rd <= 32'h108}, 32'h1);
        apb(1'b1, EVMASK_OFS, 32'hFFFF);
        toggleAngle();
        pulseBreaker();
        rdc(LOGCOUNT_OFS, 32'h1);
        apb(1'b1, EVMASK_OFS, 32'h0);
        toggleAngle();
        rdc(LOGCOUNT_OFS, 32'h1);
        pulseBreaker();
        rdc(LOGCOUNT_OFS, 32'h2);
        $display("test events done");
        report_and_stop();
    end
endmodule
`default_nettype wire

// ---- test/sync_permit_props.sv ----
// Checker for the close-permit block, bound to its top module.
// Assumes a single clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sync_permit_props import sync_permit_pkg::*; (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic permitPickup,
    input wire logic permitOut
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("no pready");
    property p_ready_after_setup; psel && !penable && ce |=> pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
    property p_ready_pulse; pready && ce |=> !pready; endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("pready without setup");
    property p_ready_cause; pready |-> $past(psel && !penable); endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("lone pslverr");
    property p_err_with_ready; pslverr |-> pready; endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");
    property p_err_unmapped;
        psel && !penable && ce && (paddr > LOGCOUNT_OFS || paddr[1:0] != 2'h0)
            |=> pslverr && prdata == 32'h0;
    endproperty
    a_mapped_ok: assert property (p_mapped_ok) else $error("mapped refused");
    property p_mapped_ok;
        psel && !penable && ce && paddr <= LOGCOUNT_OFS && paddr[1:0] == 2'h0 |=> !pslverr;
    endproperty
    a_out_after_pickup: assert property (p_out_after_pickup) else $error("early out");
    property p_out_after_pickup; $rose(permitOut) |-> $past(permitPickup); endproperty
    a_drop_clears: assert property (p_drop_clears) else $error("out kept");
    property p_drop_clears; $fell(permitPickup) |=> !permitOut; endproperty
endmodule
bind sync_permit sync_permit_props u_props (.mclk(mclk), .rst_n(rst_n), .ce(ce),
    .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .permitPickup(permitPickup), .permitOut(permitOut));
`default_nettype wire
